// ===== rtl/video_preamp_control_registers.sv
`timescale 1ns/100ps

module video_preamp_control_registers
  import preamp_ctrl_pkg::*;
  (
  input wire logic clock,
  input wire logic reset_n,
  // register port from the serial engine
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [15:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  // video timing from the core, same clock
  input wire logic hBlankIn,
  input wire logic vBlankIn,
  input wire logic fieldStart,
  // pins from outside the clock domain
  input wire logic staticBlankPin,
  input wire logic flybackPin,
  input wire logic clampPin,
  // converter controls
  output logic [7:0] fourthConverterLevel,
  output logic [2:0] levelShiftCode,
  output logic [1:0] osdContrast,
  output logic converterRangeHalve,
  output logic fourthConverterMix,
  // amplifier and video path controls
  output logic blankOut,
  output logic ampSleep,
  output logic [1:0] loopRangeOut,
  output logic flybackToLoop,
  output logic overlayOnly,
  output logic clampToCore,
  output logic burnInScreen,
  output logic jitterPhase,
  output logic abortOperations
  );

  // ********************************
  // address decode
  // ********************************

  // exact match on the full sixteen-bit address
  function automatic logic hit(input logic [15:0] addr, input logic [15:0] target);
    hit = (addr == target);
  endfunction

  logic [7:0] fourthLevel;
  logic [6:0] offsetConfig;
  logic [1:0] global_video_control;
  logic [7:0] loopOptions;
  logic softReset;
  soft_reset_state_t srState;
  logic [3:0] srCount;

  wire hitFourth = hit(regAddr, ADDR_FOURTH_LEVEL);
  wire hitOffset = hit(regAddr, ADDR_OFFSET_CONFIG);
  wire hitGlobal = hit(regAddr, ADDR_GLOBAL_CTRL);
  wire hitLoop = hit(regAddr, ADDR_LOOP_OPTIONS);
  wire hitSoft = hit(regAddr, ADDR_SOFT_RESET);

  // writes to other registers lose against a running soft reset
  wire writeOpen = regWrite && (srState == SR_IDLE);
  wire writeFourth = writeOpen && hitFourth;
  wire writeOffset = writeOpen && hitOffset;
  wire writeGlobal = writeOpen && hitGlobal;
  wire writeLoop = writeOpen && hitLoop;
  wire startSoft = writeOpen && hitSoft && regWdata[SOFT_RESET_BIT];
  wire reloadDefaults = (srState == SR_BUSY);

  // ********************************
  // pin synchronisers
  // ********************************
  logic [2:0] pinSync;

  sync_two_ff #(.WIDTH(3)) pinSyncInst (
    .clock(clock),
    .reset_n(reset_n),
    .asyncIn({clampPin, flybackPin, staticBlankPin}),
    .syncOut(pinSync)
  );

  wire staticBlank = pinSync[0];
  wire flybackSync = pinSync[1];
  wire clampSync = pinSync[2];

  // ********************************
  // soft reset sequencer
  // ********************************

  // counts a fixed number of cycles so the rest of the chip sees a clean abort
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      srState <= SR_IDLE;
      srCount <= 4'h0;
    end
    else
    begin
      case (srState)
        SR_IDLE:
        begin
          if (startSoft)
          begin
            srState <= SR_BUSY;
            srCount <= SOFT_RESET_CYCLES;
          end
        end
        SR_BUSY:
        begin
          if (srCount == 4'h1)
            srState <= SR_IDLE;
          srCount <= srCount - 4'h1;
        end
        default:
          srState <= SR_IDLE;
      endcase
    end
  end

  // status bit follows the sequencer, polled by software
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      softReset <= 1'b0;
    else
      softReset <= startSoft || (reloadDefaults && srCount != 4'h1);
  end

  // ********************************
  // control registers
  // ********************************

  // fourth converter level
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      fourthLevel <= RESET_FOURTH_LEVEL;
    else if (reloadDefaults)
      fourthLevel <= RESET_FOURTH_LEVEL;
    else if (writeFourth)
      fourthLevel <= regWdata;
  end

  // offset, overlay contrast, converter configuration; bit 7 not stored
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      offsetConfig <= RESET_OFFSET_CONFIG;
    else if (reloadDefaults)
      offsetConfig <= RESET_OFFSET_CONFIG;
    else if (writeOffset)
      offsetConfig <= regWdata[6:0];
  end

  // global blank and sleep; revision bits have no storage
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      global_video_control <= RESET_GLOBAL_CTRL;
    else if (reloadDefaults)
      global_video_control <= RESET_GLOBAL_CTRL;
    else if (writeGlobal)
      global_video_control <= regWdata[AMP_SLEEP_BIT:FORCE_BLANK_BIT];
  end

  // loop range, blanking and video path options
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      loopOptions <= RESET_LOOP_OPTIONS;
    else if (reloadDefaults)
      loopOptions <= RESET_LOOP_OPTIONS;
    else if (writeLoop)
      loopOptions <= regWdata;
  end

  // ********************************
  // read-back
  // ********************************

  // reads stay served during a soft reset so serial access completes
  wire [7:0] readMux =
    hitFourth ? fourthLevel :
    hitOffset ? {1'b0, offsetConfig} :
    hitGlobal ? {DIE_REVISION, global_video_control} :
    hitLoop ? loopOptions :
    hitSoft ? {7'h00, softReset} :
    8'h00;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      regRdata <= 8'h00;
    else if (regRead)
      regRdata <= readMux;
  end

  // ********************************
  // derived video controls
  // ********************************

  wire forceBlank = global_video_control[FORCE_BLANK_BIT];
  wire sleepBit = global_video_control[AMP_SLEEP_BIT];
  wire vblankOff = loopOptions[VBLANK_OFF_BIT];

  // every blank source merges here; sleep forces blank too
  wire next_blankOut = forceBlank || sleepBit || hBlankIn || staticBlank
    || (vBlankIn && !vblankOff);

  // flyback pulse reaches the loop only while the gate bit is clear
  wire next_flyback = flybackSync && !loopOptions[FLYBACK_GATE_BIT];

  // clamp is normalised to positive-going for the core
  wire next_clamp = clampSync ^ loopOptions[CLAMP_POLARITY_BIT];

  // jitter phase flips each field in interlace mode, held low otherwise
  wire next_jitter = loopOptions[INTERLACE_BIT] ? (jitterPhase ^ fieldStart) : 1'b0;

  // ********************************
  // output registers
  // ********************************

  // converter and offset controls
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fourthConverterLevel <= RESET_FOURTH_LEVEL;
      levelShiftCode <= RESET_OFFSET_CONFIG[SHIFT_MSB:SHIFT_LSB];
      osdContrast <= RESET_OFFSET_CONFIG[CONTRAST_MSB:CONTRAST_LSB];
      converterRangeHalve <= RESET_OFFSET_CONFIG[RANGE_HALVE_BIT];
      fourthConverterMix <= RESET_OFFSET_CONFIG[MIX_BIT];
    end
    else
    begin
      fourthConverterLevel <= fourthLevel;
      levelShiftCode <= offsetConfig[SHIFT_MSB:SHIFT_LSB];
      osdContrast <= offsetConfig[CONTRAST_MSB:CONTRAST_LSB];
      converterRangeHalve <= offsetConfig[RANGE_HALVE_BIT];
      fourthConverterMix <= offsetConfig[MIX_BIT];
    end
  end

  // video path, amplifier and loop controls
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      blankOut <= 1'b1;
      ampSleep <= 1'b0;
      loopRangeOut <= RESET_LOOP_OPTIONS[LOOP_RANGE_MSB:LOOP_RANGE_LSB];
      flybackToLoop <= 1'b0;
      overlayOnly <= 1'b0;
      clampToCore <= 1'b0;
      burnInScreen <= 1'b0;
      jitterPhase <= 1'b0;
    end
    else
    begin
      blankOut <= next_blankOut;
      ampSleep <= sleepBit;
      loopRangeOut <= loopOptions[LOOP_RANGE_MSB:LOOP_RANGE_LSB];
      flybackToLoop <= next_flyback;
      overlayOnly <= loopOptions[OVERLAY_ONLY_BIT];
      clampToCore <= next_clamp;
      burnInScreen <= loopOptions[BURN_IN_BIT];
      jitterPhase <= next_jitter;
    end
  end

  // abort to the rest of the chip; the serial engine does not take it
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      abortOperations <= 1'b0;
    else
      abortOperations <= startSoft || (reloadDefaults && srCount != 4'h1);
  end

endmodule

// ===== rtl/preamp_ctrl_pkg.sv
package preamp_ctrl_pkg;

  // ********************************
  // register addresses on the serial port
  // ********************************
  localparam logic [15:0] ADDR_FOURTH_LEVEL = 16'h0817;
  localparam logic [15:0] ADDR_OFFSET_CONFIG = 16'h0818;
  localparam logic [15:0] ADDR_GLOBAL_CTRL = 16'h0819;
  localparam logic [15:0] ADDR_LOOP_OPTIONS = 16'h081E;
  localparam logic [15:0] ADDR_SOFT_RESET = 16'h081F;

  // ********************************
  // field positions, offset/contrast/config register
  // ********************************
  localparam int SHIFT_LSB = 0;
  localparam int SHIFT_MSB = 2;
  localparam int CONTRAST_LSB = 3;
  localparam int CONTRAST_MSB = 4;
  localparam int RANGE_HALVE_BIT = 5;
  localparam int MIX_BIT = 6;

  // ********************************
  // field positions, global control register
  // ********************************
  localparam int FORCE_BLANK_BIT = 0;
  localparam int AMP_SLEEP_BIT = 1;
  localparam int REVISION_LSB = 2;
  localparam int REVISION_MSB = 7;

  // ********************************
  // field positions, loop/blank/clamp register
  // ********************************
  localparam int LOOP_RANGE_LSB = 0;
  localparam int LOOP_RANGE_MSB = 1;
  localparam int VBLANK_OFF_BIT = 2;
  localparam int OVERLAY_ONLY_BIT = 3;
  localparam int FLYBACK_GATE_BIT = 4;
  localparam int CLAMP_POLARITY_BIT = 5;
  localparam int BURN_IN_BIT = 6;
  localparam int INTERLACE_BIT = 7;

  // ********************************
  // field position, soft reset register
  // ********************************
  localparam int SOFT_RESET_BIT = 0;

  // ********************************
  // reset values
  // ********************************
  localparam logic [7:0] RESET_FOURTH_LEVEL = 8'h00;
  localparam logic [6:0] RESET_OFFSET_CONFIG = 7'h00;
  localparam logic [1:0] RESET_GLOBAL_CTRL = 2'h0;
  localparam logic [7:0] RESET_LOOP_OPTIONS = 8'h04;
  // arbitrary value, stands in for the mask-programmed revision
  localparam logic [5:0] DIE_REVISION = 6'h15;

  // ********************************
  // timing
  // ********************************
  localparam int CLOCK_MHZ = 125;
  localparam int SOFT_RESET_NS = 32;
  localparam int SOFT_RESET_CYCLES_INT = (SOFT_RESET_NS * CLOCK_MHZ + 999) / 1000;
  localparam logic [3:0] SOFT_RESET_CYCLES = SOFT_RESET_CYCLES_INT[3:0];

  typedef enum logic [0:0] {
    SR_IDLE,
    SR_BUSY
  } soft_reset_state_t;

endpackage

// ===== rtl/sync_two_ff.sv
`timescale 1ns/100ps

// ********************************
// two-stage synchroniser for pin inputs
// ********************************
module sync_two_ff
  #(parameter int WIDTH = 1)
  (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
  );

  logic [WIDTH-1:0] firstStage;

  // first stage is read only by the second stage
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      firstStage <= '0;
      syncOut <= '0;
    end
    else
    begin
      firstStage <= asyncIn;
      syncOut <= firstStage;
    end
  end

endmodule

// ===== bench/preamp_ctrl_sva.sv
`timescale 1ns/100ps

// ****************
// register port and blanking checks
// ****************
module preamp_ctrl_sva
  import preamp_ctrl_pkg::*;
  (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [15:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic hBlankIn,
  input wire logic [7:0] fourthConverterLevel,
  input wire logic [2:0] levelShiftCode,
  input wire logic [1:0] osdContrast,
  input wire logic converterRangeHalve,
  input wire logic fourthConverterMix,
  input wire logic blankOut,
  input wire logic ampSleep,
  input wire logic [1:0] loopRangeOut,
  input wire logic overlayOnly,
  input wire logic burnInScreen,
  input wire logic abortOperations
  );
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // writes taken outside a soft reset reach the pins two edges on
  level_write_a: assert property (regWrite && regAddr == ADDR_FOURTH_LEVEL && !abortOperations
    |=> ##1 fourthConverterLevel == $past(regWdata, 2)) else $error("level not applied");
  config_write_a: assert property (regWrite && regAddr == ADDR_OFFSET_CONFIG && !abortOperations
    |=> ##1 {1'b0, fourthConverterMix, converterRangeHalve, osdContrast, levelShiftCode}
    == ($past(regWdata, 2) & 8'h7F)) else $error("config not applied");
  loop_write_a: assert property (regWrite && regAddr == ADDR_LOOP_OPTIONS && !abortOperations
    |=> ##1 {1'b0, burnInScreen, 2'b00, overlayOnly, 1'b0, loopRangeOut}
    == ($past(regWdata, 2) & 8'h4B)) else $error("loop options wrong");
  sleep_blank_a: assert property (ampSleep && $past(ampSleep) |-> blankOut)
    else $error("sleep not blanking");
  hblank_blank_a: assert property (hBlankIn |=> blankOut) else $error("hblank lost");
  revision_read_a: assert property (regRead && regAddr == ADDR_GLOBAL_CTRL
    |=> regRdata[7:2] == DIE_REVISION) else $error("revision wrong");
  reserved_read_a: assert property (regRead && regAddr == ADDR_SOFT_RESET
    |=> regRdata[7:1] == 7'h00) else $error("reserved bits set");
  // busy for exactly the reload length, then the status drops by itself
  soft_busy_a: assert property (regWrite && regAddr == ADDR_SOFT_RESET && regWdata[0]
    && !abortOperations |=> abortOperations [*4] ##1 !abortOperations)
    else $error("soft reset length wrong");
  reload_a: assert property ($fell(abortOperations) |-> fourthConverterLevel == RESET_FOURTH_LEVEL
    && loopRangeOut == RESET_LOOP_OPTIONS[1:0] && !ampSleep)
    else $error("defaults not reloaded");
  cover property (regWrite && regAddr == ADDR_LOOP_OPTIONS);
  cover property ($fell(abortOperations));
  cover property (regRead && regAddr == ADDR_GLOBAL_CTRL);
endmodule

bind video_preamp_control_registers preamp_ctrl_sva chk_u (.*);

// ===== bench/reg_port_master.sv
`timescale 1ns/100ps

// ****************
// serial engine stand-in
// ****************
module reg_port_master
  (
  input wire logic clock,
  input wire logic [7:0] regRdata,
  output logic regWrite,
  output logic regRead,
  output logic [15:0] regAddr,
  output logic [7:0] regWdata
  );
  // idle port at time zero
  initial
  begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 16'h0000;
    regWdata = 8'h00;
  end
  // strobe held to its sampling edge, then address and data turn to junk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
  begin
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clock);
    regWrite <= 1'b0;
    regAddr <= ~a;
    regWdata <= ~d;
  end
  endtask
  // read data is taken once the strobe edge has landed
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
  begin
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    regAddr <= ~a;
    #1;
    d = regRdata;
  end
  endtask
endmodule

// ===== bench/test_video_preamp_control_registers.sv
`timescale 1ns/100ps

// ****************
// register bank bench
// ****************
module test_video_preamp_control_registers
  import preamp_ctrl_pkg::*;
  ;
  logic clock, reset_n, regWrite, regRead, hBlankIn, vBlankIn, fieldStart;
  logic staticBlankPin, flybackPin, clampPin, converterRangeHalve, fourthConverterMix;
  logic blankOut, ampSleep, flybackToLoop, overlayOnly, clampToCore, burnInScreen;
  logic jitterPhase, abortOperations;
  logic [15:0] regAddr;
  logic [7:0] regWdata, regRdata, fourthConverterLevel, rd;
  logic [2:0] levelShiftCode;
  logic [1:0] osdContrast, loopRangeOut;
  int nMismatch, checksDone;

  video_preamp_control_registers dut_u (.*);
  reg_port_master mst_u (.*);

  // free-running 125 MHz clock
  always #4 clock = ~clock;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
  begin
    checksDone++;
    if (got !== exp)
    begin
      nMismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
  begin
    mst_u.rd(a, rd);
    chk(rd, exp);
  end
  endtask
  // four edges cover the three-edge pin path and the two-edge write path
  task automatic settle;
  begin
    repeat (4) @(posedge clock);
    #1;
  end
  endtask
  task automatic pins(input logic [4:0] v);
  begin
    @(posedge clock);
    {hBlankIn, vBlankIn, staticBlankPin, flybackPin, clampPin} <= v;
    settle;
  end
  endtask
  task automatic s_reset_vals;
  begin
    rchk(ADDR_FOURTH_LEVEL, 8'h00);
    rchk(ADDR_OFFSET_CONFIG, 8'h00);
    rchk(ADDR_GLOBAL_CTRL, {DIE_REVISION, 2'b00});
    rchk(ADDR_LOOP_OPTIONS, 8'h04);
    rchk(ADDR_SOFT_RESET, 8'h00);
    rchk(16'h0820, 8'h00);
  end
  endtask
  task automatic s_fields;
  begin
    mst_u.wr(ADDR_FOURTH_LEVEL, 8'hA5);
    mst_u.wr(ADDR_OFFSET_CONFIG, 8'hFF);
    mst_u.wr(ADDR_GLOBAL_CTRL, 8'hFE);
    settle;
    chk(fourthConverterLevel, 8'hA5);
    chk({1'b0, fourthConverterMix, converterRangeHalve, osdContrast, levelShiftCode}, 8'h7F);
    chk({6'h00, ampSleep, blankOut}, 8'h03);
    rchk(ADDR_OFFSET_CONFIG, 8'h7F);
    rchk(ADDR_GLOBAL_CTRL, {DIE_REVISION, 2'b10});
    mst_u.wr(ADDR_GLOBAL_CTRL, 8'h01);
    settle;
    chk({6'h00, ampSleep, blankOut}, 8'h01);
    for (int i = 0; i < 4; i++)
    begin
      mst_u.wr(ADDR_LOOP_OPTIONS, {1'b0, i[0], 2'b00, i[1], 1'b1, i[1:0]});
      settle;
      chk({4'h0, burnInScreen, overlayOnly, loopRangeOut}, {4'h0, i[0], i[1], i[1:0]});
    end
  end
  endtask
  task automatic s_pins;
  begin
    mst_u.wr(ADDR_GLOBAL_CTRL, 8'h00);
    pins(5'b00011);
    chk({5'h00, flybackToLoop, clampToCore, blankOut}, 8'h06);
    mst_u.wr(ADDR_LOOP_OPTIONS, 8'h34);
    pins(5'b01011);
    chk({5'h00, flybackToLoop, clampToCore, blankOut}, 8'h00);
    mst_u.wr(ADDR_LOOP_OPTIONS, 8'h80);
    settle;
    chk(blankOut, 8'h01);
    pins(5'b00100);
    chk(blankOut, 8'h01);
    pins(5'b10000);
    chk(blankOut, 8'h01);
    @(posedge clock);
    fieldStart <= 1'b1;
    pins(5'b00000);
    chk({jitterPhase, blankOut}, 8'h02);
  end
  endtask
  task automatic s_soft_reset;
  begin
    mst_u.wr(ADDR_GLOBAL_CTRL, 8'h02);
    mst_u.wr(ADDR_SOFT_RESET, 8'hFF);
    mst_u.wr(ADDR_FOURTH_LEVEL, 8'h33);
    rchk(ADDR_SOFT_RESET, 8'h01);
    for (int n = 0; n < 20 && rd !== 8'h00; n++)
      mst_u.rd(ADDR_SOFT_RESET, rd);
    chk(rd, 8'h00);
    // a status bit that never drops has been counted; stop here
    if (rd !== 8'h00)
      results;
    settle;
    chk(fourthConverterLevel, 8'h00);
    chk({7'h00, jitterPhase}, 8'h00);
    chk({ampSleep, blankOut}, 8'h00);
    rchk(ADDR_LOOP_OPTIONS, 8'h04);
  end
  endtask
  task automatic results;
  begin
    if (nMismatch == 0 && checksDone > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask

  // main sequence; the single-cycle field pulse is dropped one edge on
  always @(posedge clock) if (fieldStart) fieldStart <= 1'b0;
  initial
  begin
    clock = 1'b0;
    reset_n = 1'b0;
    {hBlankIn, vBlankIn, staticBlankPin, flybackPin, clampPin, fieldStart} = 6'h00;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    s_reset_vals;
    s_fields;
    s_pins;
    s_soft_reset;
    results;
  end
endmodule
